// file: design/prcr_regs.v
// Operation
// - scratch byte, read/write, no effect
// - two more scratch bytes at top
// - read-only protocol revision byte
// - sixteen-bit maker code, low byte first
// - commit copies staged values to live
// - commit bit live and self-clearing
// - reference divided by eight-bit ratio
// - override bit picks pin or register
// - pin high first, low second input
// - register bit one first, zero second
// - divider clear pulse, self-clearing
// - divider clear acts without commit
`timescale 1ns/1ns
`include "prcr_defines.vh"
module prcr_regs #(
    // arbitrary neutral identity values
    parameter [7:0] PROTOCOL_REVISION = 8'h11,
    parameter [15:0] MAKER_CODE = 16'h1234
) (
    input wire mclk,
    input wire rst_n,
    input wire wr_en,
    input wire rd_en,
    input wire [11:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    input wire ref_sel_pin,
    output reg [7:0] live_divide_ratio,
    output reg live_choice_by_pin_override,
    output reg live_choice_register_bit,
    output wire select_first_reference,
    output reg ref_divider_clear,
    output reg commit_pulse
);

reg [7:0] scratch_reg [0:2];
reg [7:0] rdiv_reg;
reg [2:1] rctrl_reg;
reg [7:0] rd_next;
reg [7:0] live_divide_ratio_next;
reg live_override_next;
reg live_choice_next;
reg commit_pulse_next;
reg divider_clear_next;
wire wr_scratch;
wire wr_rdiv;
wire wr_rctrl;
wire wr_commit;
integer i;

// scratch decode, shared by the write and read paths
function is_scratch;
    input [11:0] a;
    begin
        is_scratch = (a == `PRCR_ADDR_SCRATCH0)
            || (a == `PRCR_ADDR_SCRATCH1)
            || (a == `PRCR_ADDR_SCRATCH2);
    end
endfunction

function [1:0] scratch_index;
    input [11:0] a;
    begin
        case (a)
            `PRCR_ADDR_SCRATCH1:
                scratch_index = 2'h1;
            `PRCR_ADDR_SCRATCH2:
                scratch_index = 2'h2;
            default:
                scratch_index = 2'h0;
        endcase
    end
endfunction

// control byte as read back: reserved bits and the live clear read zero
function [7:0] rctrl_view;
    input [2:1] staged;
    begin
        rctrl_view = `PRCR_ZERO8;
        rctrl_view[`PRCR_BIT_OVERRIDE] = staged[`PRCR_BIT_OVERRIDE];
        rctrl_view[`PRCR_BIT_CHOICE] = staged[`PRCR_BIT_CHOICE];
    end
endfunction

assign wr_scratch = wr_en && is_scratch(addr);
assign wr_rdiv = wr_en && (addr == `PRCR_ADDR_RDIV);
assign wr_rctrl = wr_en && (addr == `PRCR_ADDR_RCTRL);
assign wr_commit = wr_en && (addr == `PRCR_ADDR_COMMIT) && wr_data[`PRCR_BIT_COMMIT];

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        for (i = 0; i < `PRCR_NUM_SCRATCH; i = i + 1)
        begin
            scratch_reg[i] <= `PRCR_RST_SCRATCH;
        end
    end
    else if (wr_scratch)
    begin
        scratch_reg[scratch_index(addr)] <= wr_data;
    end
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        rdiv_reg <= `PRCR_RST_RDIV;
    end
    else if (wr_rdiv)
    begin
        rdiv_reg <= wr_data;
    end
end

// staged selection
// upper bits dropped, so a careless host cannot corrupt them
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        rctrl_reg <= `PRCR_RST_CHOICES;
    end
    else if (wr_rctrl)
    begin
        rctrl_reg <= wr_data[`PRCR_RCTRL_MSB:`PRCR_BIT_CHOICE];
    end
end

// commit copies staged
// a commit in the same cycle as a ctrl write takes the old staged byte
always @*
begin
    live_divide_ratio_next = live_divide_ratio;
    live_override_next = live_choice_by_pin_override;
    live_choice_next = live_choice_register_bit;
    if (wr_commit)
    begin
        live_divide_ratio_next = rdiv_reg;
        live_override_next = rctrl_reg[`PRCR_BIT_OVERRIDE];
        live_choice_next = rctrl_reg[`PRCR_BIT_CHOICE];
    end
end

always @*
begin
    commit_pulse_next = wr_commit;
end

always @*
begin
    divider_clear_next = wr_rctrl && wr_data[`PRCR_BIT_DIVCLR];
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        live_divide_ratio <= `PRCR_RST_RDIV;
        live_choice_by_pin_override <= `PRCR_RST_OVERRIDE;
        live_choice_register_bit <= `PRCR_RST_CHOICE;
    end
    else
    begin
        live_divide_ratio <= live_divide_ratio_next;
        live_choice_by_pin_override <= live_override_next;
        live_choice_register_bit <= live_choice_next;
    end
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        commit_pulse <= `PRCR_PULSE_IDLE;
        ref_divider_clear <= `PRCR_PULSE_IDLE;
    end
    else
    begin
        commit_pulse <= commit_pulse_next;
        ref_divider_clear <= divider_clear_next;
    end
end

assign select_first_reference = live_choice_by_pin_override ? ref_sel_pin
    : live_choice_register_bit;

always @*
begin
    rd_next = `PRCR_ZERO8;
    if (is_scratch(addr))
    begin
        rd_next = scratch_reg[scratch_index(addr)];
    end
    else
    begin
        case (addr)
            `PRCR_ADDR_REVISION:
                rd_next = PROTOCOL_REVISION;
            `PRCR_ADDR_MAKER_LO:
                rd_next = MAKER_CODE[7:0];
            `PRCR_ADDR_MAKER_HI:
                rd_next = MAKER_CODE[15:8];
            `PRCR_ADDR_RDIV:
                rd_next = rdiv_reg;
            `PRCR_ADDR_RCTRL:
                rd_next = rctrl_view(rctrl_reg);
            default:
                rd_next = `PRCR_ZERO8;
        endcase
    end
end

// read data holds until the next read request
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        rd_data <= `PRCR_ZERO8;
    end
    else if (rd_en)
    begin
        rd_data <= rd_next;
    end
end

endmodule // prcr_regs

// file: design/prcr_defines.vh
`ifndef PRCR_DEFINES_VH
`define PRCR_DEFINES_VH
`define PRCR_ADDR_W 12
`define PRCR_ADDR_SCRATCH0 12'h00a
`define PRCR_ADDR_REVISION 12'h00b
`define PRCR_ADDR_MAKER_LO 12'h00c
`define PRCR_ADDR_MAKER_HI 12'h00d
`define PRCR_ADDR_COMMIT 12'h00f
`define PRCR_ADDR_RDIV 12'h010
`define PRCR_ADDR_RCTRL 12'h011
`define PRCR_ADDR_SCRATCH1 12'h0fe
`define PRCR_ADDR_SCRATCH2 12'h0ff
`define PRCR_RST_SCRATCH 8'h00
`define PRCR_RST_RDIV 8'h01
`define PRCR_RST_RCTRL 3'h6
`define PRCR_RST_CHOICES 2'h3
`define PRCR_RST_OVERRIDE 1'b1
`define PRCR_RST_CHOICE 1'b1
`define PRCR_PULSE_IDLE 1'b0
`define PRCR_NUM_SCRATCH 3
`define PRCR_BIT_COMMIT 0
`define PRCR_BIT_DIVCLR 0
`define PRCR_BIT_CHOICE 1
`define PRCR_BIT_OVERRIDE 2
`define PRCR_RCTRL_MSB 2
`define PRCR_ZERO8 8'h00
`endif

// file: tb/prcr_chk.sv
`timescale 1ns/1ns
module prcr_chk (
    input wire logic mclk, rst_n, wr_en, commit_pulse, ref_divider_clear, ref_sel_pin,
    input wire logic live_choice_by_pin_override, live_choice_register_bit,
    input wire logic select_first_reference,
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data, live_divide_ratio
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire ovr = live_choice_by_pin_override;
    wire sel = select_first_reference;
    wire cp = commit_pulse;
    wire cw = wr_en && addr == 12'h00f && wr_data[0];
    wire dw = wr_en && addr == 12'h011 && wr_data[0];
    commit_go_a: assert property (cw |=> cp) else $error("commit lost");
    commit_src_a: assert property (cp |-> $past(cw)) else $error("stray commit");
    clear_go_a: assert property (dw |=> ref_divider_clear) else $error("clear lost");
    clear_src_a: assert property (ref_divider_clear |-> $past(dw)) else $error("stray clear");
    ratio_hold_a: assert property ($changed(live_divide_ratio) |-> cp) else $error("ratio");
    over_hold_a: assert property ($changed(ovr) |-> cp) else $error("override");
    choice_hold_a: assert property ($changed(live_choice_register_bit) |-> cp) else $error("choice");
    pin_sel_a: assert property (ovr |-> sel == ref_sel_pin) else $error("pin select");
    reg_sel_a: assert property (!ovr |-> sel == live_choice_register_bit) else $error("reg sel");
    cover property (cp);
    cover property (ref_divider_clear);
    cover property (!ovr && sel);
endmodule // prcr_chk
bind prcr_regs prcr_chk chk (.*);

// file: tb/prcr_host.sv
`timescale 1ns/1ns
module prcr_host (
    input wire logic mclk,
    output logic wr_en = 1'h0, rd_en = 1'h0,
    output logic [11:0] addr = 12'h000,
    output logic [7:0] wr_data = 8'h00
);
    task acc(logic w, logic [11:0] a, logic [7:0] d);
        @(negedge mclk);
        {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
        @(negedge mclk);
        // stale data inverted so a late sample cannot match
        {wr_en, rd_en, wr_data} = {2'h0, ~d};
    endtask
endmodule // prcr_host

// file: tb/test_pll_ref_config_registers.sv
`timescale 1ns/1ns
module test_pll_ref_config_registers;
    logic mclk = 1'h0, rst_n = 1'h0, ref_sel_pin = 1'h1;
    wire wr_en, rd_en, select_first_reference, ref_divider_clear, commit_pulse;
    wire live_choice_by_pin_override, live_choice_register_bit;
    wire [11:0] addr;
    wire [7:0] wr_data, rd_data, live_divide_ratio;
    int num_errors = 0, compares = 0, cyc = 0;
    prcr_host host (.*);
    prcr_regs uut (.*);
    initial forever #10 mclk = ~mclk;
    task chk(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        num_errors += int'(g !== e);
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    endtask
    task rck(logic [11:0] a, logic [7:0] e);
        host.acc(1'h0, a, 8'h00);
        chk("rd_data", e, rd_data);
    endtask
    task test_done(int e);
        num_errors += e;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk)
        if (++cyc == 999)
            test_done(1);
    initial
    begin
        repeat (16) @(negedge mclk);
        rst_n = 1'h1;
        chk("sel", 8'h01, {7'h0, select_first_reference});
        host.acc(1'h1, 12'h00a, 8'h5a);
        host.acc(1'h1, 12'h0ff, 8'ha5);
        rck(12'h00a, 8'h5a);
        rck(12'h0ff, 8'ha5);
        host.acc(1'h1, 12'h00b, 8'h5a);
        rck(12'h00b, 8'h11);
        rck(12'h00c, 8'h34);
        rck(12'h00d, 8'h12);
        host.acc(1'h1, 12'h010, 8'hff);
        rck(12'h010, 8'hff);
        chk("ratio", 8'h01, live_divide_ratio);
        host.acc(1'h1, 12'h00f, 8'h01);
        chk("commit", 8'h01, {7'h0, commit_pulse});
        chk("ratio", 8'hff, live_divide_ratio);
        ref_sel_pin = 1'h0;
        host.acc(1'h1, 12'h011, 8'h03);
        chk("clear", 8'h01, {7'h0, ref_divider_clear});
        rck(12'h011, 8'h02);
        host.acc(1'h1, 12'h00f, 8'h01);
        chk("sel", 8'h01, {7'h0, select_first_reference});
        host.acc(1'h1, 12'h011, 8'h06);
        host.acc(1'h1, 12'h00f, 8'h01);
        chk("sel", 8'h00, {7'h0, select_first_reference});
        host.acc(1'h1, 12'h011, 8'h00);
        host.acc(1'h1, 12'h00f, 8'h01);
        ref_sel_pin = 1'h1;
        chk("sel", 8'h00, {7'h0, select_first_reference});
        test_done(0);
    end
endmodule // test_pll_ref_config_registers
